// >>> logic/rcr_top.sv
/*
  Reset-time clock ratio strap block: catches the ratio straps once after
  reset, decodes platform, core and memory ratios, and drives clock-select
  outputs for the PLLs and clock muxes. Software reads the decoded ratios and
  sets the memory divide and PCI source over classic Wishbone.
  Assumes straps are held steady by the board around reset release.
*/
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module rcr_top
  import rcr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // strap pins
  input  wire logic [3:0]  platform_ratio_straps_i,
  input  wire logic        core_ratio_strap_a_i,
  input  wire logic        core_ratio_strap_b_i,
  input  wire logic        core_ratio_strap_c_i,
  input  wire logic [1:0]  timestamp_trigger_strap_pins_i,
  input  wire logic        timestamp_clock_strap_pin_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // decoded settings to the PLLs
  output logic             cfg_valid_o,
  output logic [7:0]       plat_mult_o,
  output logic [7:0]       core_num_o,
  output logic [1:0]       core_den_o,
  output logic [7:0]       mem_mult_o,
  output logic             mem_sync_o,
  output logic             mem_pll_ref_en_o,
  output logic             memory_clock_divide_setting_o,
  output logic             strap_error_o,
  output logic             pci_clk_sel_async_o
);

  localparam int SETTLE_W = $clog2(RCR_SETTLE_CYC + 1);

  rcr_state_e        state_q;
  logic [SETTLE_W-1:0] settle_q;
  rcr_straps_s       straps_q;
  rcr_straps_s       pins;
  rcr_ratio_s        plat_r;
  rcr_ratio_s        core_r;
  rcr_ratio_s        mem_r;
  logic              mem_sync;
  logic              ctrl_div_q;
  logic              ctrl_pci_q;
  logic              wb_req;
  logic [31:0]       rd_d;
  logic              hit;

  // one driver for the whole struct; field-wise assigns would give it three
  assign pins = '{plat: platform_ratio_straps_i,
                  core: {core_ratio_strap_a_i, core_ratio_strap_b_i, core_ratio_strap_c_i},
                  mem:  {timestamp_trigger_strap_pins_i, timestamp_clock_strap_pin_i}};

  // memory strap decode; the sync flag is compared on the code directly
  function automatic rcr_ratio_s mem_decode(input logic [2:0] c);
    rcr_ratio_s r;
    r = '{valid: 1'b1, num: 8'h00, den: 2'h1};
    case (c)
      3'h0:    r.num = 8'h03;
      3'h1:    r.num = 8'h04;
      3'h2:    r.num = 8'h06;
      3'h3:    r.num = 8'h08;
      3'h4:    r.num = 8'h0A;
      3'h5:    r.num = 8'h0C;
      3'h7:    r.num = 8'h00;
      default: r.valid = 1'b0;
    endcase
    return r;
  endfunction : mem_decode

  rcr_plat_dec u_plat (
    .code_i  (straps_q.plat),
    .ratio_o (plat_r)
  );

  rcr_core_dec u_core (
    .code_i  (straps_q.core),
    .ratio_o (core_r)
  );

  assign mem_r    = mem_decode(straps_q.mem);
  assign mem_sync = (straps_q.mem == 3'h7);

  // capture sequencer: straps caught once, a few cycles after release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q  <= RCR_ST_RESET;
      settle_q <= '0;
    end else begin
      case (state_q)
        RCR_ST_RESET: begin
          state_q  <= RCR_ST_WAIT;
          settle_q <= '0;
        end
        RCR_ST_WAIT: begin
          if (settle_q == SETTLE_W'(RCR_SETTLE_CYC - 1)) begin
            state_q <= RCR_ST_HOLD;
          end
          settle_q <= settle_q + 1'b1;
        end
        RCR_ST_HOLD: state_q <= RCR_ST_HOLD;
        default:     state_q <= RCR_ST_RESET;
      endcase
    end
  end

  // strap register, loaded only at the end of the settle window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      straps_q <= '0;
    end else if (state_q == RCR_ST_WAIT && settle_q == SETTLE_W'(RCR_SETTLE_CYC - 1)) begin
      straps_q <= pins;
    end
  end

  // decoded outputs, frozen once captured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_valid_o      <= 1'b0;
      plat_mult_o      <= 8'h00;
      core_num_o       <= 8'h00;
      core_den_o       <= 2'h0;
      mem_mult_o       <= 8'h00;
      mem_sync_o       <= 1'b0;
      mem_pll_ref_en_o <= 1'b0;
      strap_error_o    <= 1'b0;
    end else begin
      cfg_valid_o      <= (state_q == RCR_ST_HOLD);
      // platform = system reference times this multiplier
      plat_mult_o      <= plat_r.num;
      core_num_o       <= core_r.num;
      core_den_o       <= core_r.den;
      // async: multiplier over memory PLL reference; sync: data rate is platform
      mem_mult_o       <= mem_sync ? plat_r.num : mem_r.num;
      mem_sync_o       <= mem_sync;
      mem_pll_ref_en_o <= (state_q == RCR_ST_HOLD) && !mem_sync;
      // reserved codes cannot be served; flag rather than guess
      strap_error_o    <= (state_q == RCR_ST_HOLD) &&
                          !(plat_r.valid && core_r.valid && mem_r.valid);
    end
  end

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign hit    = (wb_adr_i == RCR_OFF_PLAT) || (wb_adr_i == RCR_OFF_CORE) ||
                  (wb_adr_i == RCR_OFF_MEM)  || (wb_adr_i == RCR_OFF_CTRL);

  // control register; the divide bit should be settled before memory init
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_div_q <= RCR_CTRL_DIV_RST;
      ctrl_pci_q <= RCR_CTRL_PCI_RST;
    end else if (wb_req && wb_we_i && wb_adr_i == RCR_OFF_CTRL && wb_sel_i[0]) begin
      ctrl_div_q <= wb_dat_i[RCR_CTRL_DIV_BIT];
      ctrl_pci_q <= wb_dat_i[RCR_CTRL_PCI_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      memory_clock_divide_setting_o <= 1'b0;
      pci_clk_sel_async_o           <= 1'b0;
    end else begin
      memory_clock_divide_setting_o <= ctrl_div_q;
      pci_clk_sel_async_o           <= ctrl_pci_q;
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    case (wb_adr_i)
      RCR_OFF_PLAT: begin
        rd_d[7:0]                        = plat_r.num;
        rd_d[RCR_CODE_LSB +: RCR_PLAT_W] = straps_q.plat;
        rd_d[RCR_VALID_BIT]              = plat_r.valid;
      end
      RCR_OFF_CORE: begin
        rd_d[7:0]                        = core_r.num;
        rd_d[RCR_DEN_LSB +: 2]           = core_r.den;
        rd_d[RCR_CODE_LSB +: RCR_SEL_W]  = straps_q.core;
        rd_d[RCR_VALID_BIT]              = core_r.valid;
      end
      RCR_OFF_MEM: begin
        rd_d[7:0]                        = mem_r.num;
        rd_d[RCR_CODE_LSB +: RCR_SEL_W]  = straps_q.mem;
        rd_d[RCR_SYNC_BIT]               = mem_sync;
        rd_d[RCR_VALID_BIT]              = mem_r.valid;
      end
      RCR_OFF_CTRL: begin
        rd_d[RCR_CTRL_DIV_BIT]           = ctrl_div_q;
        rd_d[RCR_CTRL_PCI_BIT]           = ctrl_pci_q;
        rd_d[RCR_VALID_BIT]              = (state_q == RCR_ST_HOLD);
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // one-cycle answer; unmapped addresses answer with err
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req && hit;
      wb_err_o <= wb_req && !hit;
      wb_dat_o <= (wb_req && hit && !wb_we_i) ? rd_d : 32'h0000_0000;
    end
  end

endmodule : rcr_top
`default_nettype wire

// >>> logic/rcr_pkg.sv
/*
  Constants, types and register map for the reset-time clock ratio strap decoder.
  Assumes a single 50 MHz clock domain and a classic Wishbone register port.
*/
package rcr_pkg;

  // register byte offsets
  localparam logic [3:0] RCR_OFF_PLAT   = 4'h0;
  localparam logic [3:0] RCR_OFF_CORE   = 4'h4;
  localparam logic [3:0] RCR_OFF_MEM    = 4'h8;
  localparam logic [3:0] RCR_OFF_CTRL   = 4'hC;

  // control register fields
  localparam int RCR_CTRL_DIV_BIT = 0;
  localparam int RCR_CTRL_PCI_BIT = 1;
  localparam logic RCR_CTRL_DIV_RST = 1'b0;
  localparam logic RCR_CTRL_PCI_RST = 1'b0;

  // status field positions in the decoded registers
  localparam int RCR_VALID_BIT = 31;
  localparam int RCR_SYNC_BIT  = 30;
  localparam int RCR_DEN_LSB   = 8;
  localparam int RCR_CODE_LSB  = 16;

  // cycles after release before straps are caught; lets board drivers settle
  localparam int RCR_SETTLE_CYC = 4;

  localparam int RCR_PLAT_W = 4;
  localparam int RCR_SEL_W  = 3;

  typedef enum logic [2:0] {
    RCR_ST_RESET = 3'b001,
    RCR_ST_WAIT  = 3'b010,
    RCR_ST_HOLD  = 3'b100
  } rcr_state_e;

  // ratio as numerator over denominator
  typedef struct packed {
    logic       valid;
    logic [7:0] num;
    logic [1:0] den;
  } rcr_ratio_s;

  typedef struct packed {
    logic [3:0] plat;
    logic [2:0] core;
    logic [2:0] mem;
  } rcr_straps_s;

endpackage : rcr_pkg

// >>> logic/rcr_plat_dec.sv
/*
  Platform bus ratio decoder: four strap bits to an integer multiplier.
  Assumes straps are already caught and steady.
*/
`timescale 1ns/1ps
`default_nettype none
module rcr_plat_dec
  import rcr_pkg::*;
(
  // strap code
  input  wire logic [3:0] code_i,
  // decoded ratio
  output rcr_ratio_s      ratio_o
);

  always_comb begin
    ratio_o = '{valid: 1'b1, num: 8'h00, den: 2'h1};
    case (code_i)
      4'h0:    ratio_o.num = 8'h10;
      4'h3:    ratio_o.num = 8'h03;
      4'h4:    ratio_o.num = 8'h04;
      4'h5:    ratio_o.num = 8'h05;
      4'h6:    ratio_o.num = 8'h06;
      4'h8:    ratio_o.num = 8'h08;
      4'h9:    ratio_o.num = 8'h09;
      4'hA:    ratio_o.num = 8'h0A;
      4'hC:    ratio_o.num = 8'h0C;
      default: ratio_o.valid = 1'b0;
    endcase
  end

endmodule : rcr_plat_dec
`default_nettype wire

// >>> logic/rcr_core_dec.sv
/*
  Core to platform ratio decoder: three straps to a half-step ratio.
  Assumes straps are already caught and steady.
*/
`timescale 1ns/1ps
`default_nettype none
module rcr_core_dec
  import rcr_pkg::*;
(
  // strap code
  input  wire logic [2:0] code_i,
  // decoded ratio
  output rcr_ratio_s      ratio_o
);

  always_comb begin
    ratio_o = '{valid: 1'b1, num: 8'h00, den: 2'h2};
    case (code_i)
      3'h0:    begin ratio_o.num = 8'h04; ratio_o.den = 2'h1; end
      3'h1:    ratio_o.num = 8'h09;
      3'h3:    ratio_o.num = 8'h03;
      3'h4:    begin ratio_o.num = 8'h02; ratio_o.den = 2'h1; end
      3'h5:    ratio_o.num = 8'h05;
      3'h6:    begin ratio_o.num = 8'h03; ratio_o.den = 2'h1; end
      3'h7:    ratio_o.num = 8'h07;
      default: ratio_o.valid = 1'b0;
    endcase
  end

endmodule : rcr_core_dec
`default_nettype wire

// >>> testbench/rcr_monitor.sv
/*
  Port-level checks for the reset-time clock ratio strap block.
  Bound into rcr_top from the testbench; a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module rcr_monitor (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  // decoded settings
  input wire logic        cfg_valid_o,
  input wire logic [7:0]  plat_mult_o,
  input wire logic [7:0]  core_num_o,
  input wire logic [1:0]  core_den_o,
  input wire logic [7:0]  mem_mult_o,
  input wire logic        mem_sync_o,
  input wire logic        mem_pll_ref_en_o,
  input wire logic        memory_clock_divide_setting_o,
  input wire logic        pci_clk_sel_async_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  sequence s_ctrl_wr;
    take && wb_we_i && wb_adr_i == 4'hC && wb_sel_i[0];
  endsequence
  // capture waits out the settle count, then valid rises and holds for two cycles
  sequence s_settle;
    !cfg_valid_o [*5] ##[1:4] cfg_valid_o [*2];
  endsequence
  AST_ACK_LAT: assert property (take && wb_adr_i[1:0] == 2'h0 |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acknowledged one cycle later");
  AST_ERR_LAT: assert property (take && wb_adr_i[1:0] != 2'h0 |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused one cycle later");
  AST_ACK_ONE: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
    else $error("bus answer stood longer than one cycle");
  AST_CAPTURE: assert property ($fell(rst_i) |-> s_settle)
    else $error("capture timing after reset release wrong");
  AST_HOLD: assert property (cfg_valid_o |=> $stable({plat_mult_o, core_num_o, core_den_o, mem_mult_o}))
    else $error("decoded ratio changed after capture");
  AST_SYNC_RATE: assert property (cfg_valid_o && mem_sync_o |-> mem_mult_o == plat_mult_o)
    else $error("sync memory rate differs from platform rate");
  AST_REF_EN: assert property (cfg_valid_o |-> mem_pll_ref_en_o == !mem_sync_o)
    else $error("memory reference enable disagrees with mode");
  AST_DIV_WR: assert property (s_ctrl_wr |-> ##2 memory_clock_divide_setting_o == $past(wb_dat_i[0], 2))
    else $error("divide setting not following control write");
  AST_PCI_WR: assert property (s_ctrl_wr |-> ##2 pci_clk_sel_async_o == $past(wb_dat_i[1], 2))
    else $error("pci clock source not following control write");
endmodule : rcr_monitor
`default_nettype wire

// >>> testbench/rcr_strap_model.sv
/*
  Board strap model: drives the ratio strap pins hard from a wanted code set.
  Assumes the testbench changes the code around reset, and once after capture to check the hold.
*/
`timescale 1ns/1ps
`default_nettype none
module rcr_strap_model
  import rcr_pkg::*;
(
  // wanted codes
  input  wire rcr_straps_s straps_i,
  // strap pins
  output logic [3:0]       plat_o,
  output logic             core_a_o,
  output logic             core_b_o,
  output logic             core_c_o,
  output logic [1:0]       trig_o,
  output logic             clk_pin_o
);
  // always driven: a floating platform strap has no fallback ratio
  assign plat_o = straps_i.plat;
  assign {core_a_o, core_b_o, core_c_o} = straps_i.core;
  // the memory reference clock itself is only needed when async
  assign {trig_o, clk_pin_o} = straps_i.mem;
endmodule : rcr_strap_model
`default_nettype wire

// >>> testbench/testbench.sv
/*
  Self-checking bench for rcr_top: walks every strap code through resets,
  then exercises the control register and bus refusals.
  Assumes rcr_pkg, the design and the strap model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rcr_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, pc;
  logic [3:0] sel = 4'hF, wsel = 4'hF;
  logic [9:0] cx;
  logic [31:0] dat = 32'h0, q, wd;
  logic e, ack, err, valid, msync, refen, divo, serr, pcio;
  logic [3:0] p_pin;
  logic a_pin, b_pin, c_pin, k_pin;
  logic [1:0] t_pin, cden;
  logic [7:0] pmul, cnum, mmul;
  logic [2:0] cc, mc;
  rcr_straps_s st = '0;
  int err_total = 0, cmp_count = 0, n;
  initial forever #10 clk_i = ~clk_i;
  rcr_strap_model u_board (.straps_i(st), .plat_o(p_pin), .core_a_o(a_pin), .core_b_o(b_pin),
    .core_c_o(c_pin), .trig_o(t_pin), .clk_pin_o(k_pin));
  rcr_top u_dut (.clk_i, .rst_i, .platform_ratio_straps_i(p_pin), .core_ratio_strap_a_i(a_pin),
    .core_ratio_strap_b_i(b_pin), .core_ratio_strap_c_i(c_pin),
    .timestamp_trigger_strap_pins_i(t_pin), .timestamp_clock_strap_pin_i(k_pin),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack), .wb_err_o(err), .cfg_valid_o(valid),
    .plat_mult_o(pmul), .core_num_o(cnum), .core_den_o(cden), .mem_mult_o(mmul),
    .mem_sync_o(msync), .mem_pll_ref_en_o(refen), .memory_clock_divide_setting_o(divo),
    .strap_error_o(serr), .pci_clk_sel_async_o(pcio));
  function automatic logic [7:0] pexp(input logic [3:0] c);
    case (c)
      4'h0: return 8'h10;
      4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hC: return {4'h0, c};
      default: return 8'h00;
    endcase
  endfunction : pexp
  function automatic logic [9:0] cexp(input logic [2:0] c);
    case (c)
      3'h0: return {8'h04, 2'h1};
      3'h1: return {8'h09, 2'h2};
      3'h3: return {8'h03, 2'h2};
      3'h4: return {8'h02, 2'h1};
      3'h5: return {8'h05, 2'h2};
      3'h6: return {8'h03, 2'h1};
      default: return {8'h07, 2'h2};
    endcase
  endfunction : cexp
  function automatic logic [7:0] mexp(input logic [2:0] c);
    case (c)
      3'h0: return 8'h03;
      3'h1: return 8'h04;
      3'h2: return 8'h06;
      3'h3: return 8'h08;
      3'h4: return 8'h0A;
      default: return 8'h0C;
    endcase
  endfunction : mexp
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= wsel;
    // no cycle limit here: only the watchdog ends a wait
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && err !== 1'b1);
    wd = q;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    // taken at the first edge, answer sampled at the second
    chk("bus_latency", 32'd2, k);
  endtask : wb
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  initial begin
    #400000;
    err_total++;
    complete_run();
  end
  initial begin
    for (int i = 0; i < 16; i++) begin
      pc = i[3:0];
      cc = i[2:0];
      mc = i[2:0] + 3'h1;
      @(posedge clk_i);
      st <= '{plat: pc, core: cc, mem: mc};
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      n = 0;
      while (valid !== 1'b1 && n < 30) begin
        @(posedge clk_i);
        n++;
      end
      chk("cfg_valid", 1'b1, valid);
      chk("plat_mult", pexp(pc), pmul);
      if (cc != 3'h2) chk("core_ratio", cexp(cc), {cnum, cden});
      chk("mem_sync", mc == 3'h7, msync);
      chk("mem_ref_en", mc != 3'h7, refen);
      if (mc == 3'h7) chk("mem_mult", pexp(pc), mmul);
      else if (mc != 3'h6) chk("mem_mult", mexp(mc), mmul);
      chk("strap_err", pexp(pc) == 0 || cc == 3'h2 || mc == 3'h6, serr);
      wb(1'b0, RCR_OFF_PLAT, 32'h0);
      chk("plat_reg", {pexp(pc) != 8'h00, 11'h000, pc, 8'h00, pexp(pc)}, wd);
      wb(1'b0, RCR_OFF_CORE, 32'h0);
      cx = (cc == 3'h2) ? {8'h00, 2'h2} : cexp(cc);
      chk("core_reg", {cc != 3'h2, 12'h000, cc, 6'h00, cx[1:0], cx[9:2]}, wd);
      wb(1'b0, RCR_OFF_MEM, 32'h0);
      chk("mem_reg", {mc != 3'h6, mc == 3'h7, 11'h000, mc, 8'h00,
        ((mc[2:1] == 2'h3) ? 8'h00 : mexp(mc))}, wd);
      st <= ~st;
      repeat (3) @(posedge clk_i);
      chk("plat_hold", pexp(pc), pmul);
    end
    // divide and pci source are set before any memory bring-up
    for (int d = 1; d < 3; d++) begin
      wb(1'b1, RCR_OFF_CTRL, d);
      wb(1'b0, RCR_OFF_CTRL, 32'h0);
      chk("ctrl_reg", 32'h8000_0000 | d, wd);
      chk("div_out", d == 1, divo);
      chk("pci_out", d == 2, pcio);
    end
    // a control write without byte lane 0 must leave the settings alone
    wsel = 4'h0;
    wb(1'b1, RCR_OFF_CTRL, 32'h1);
    wsel = 4'hF;
    wb(1'b0, RCR_OFF_CTRL, 32'h0);
    chk("ctrl_sel", 32'h8000_0002, wd);
    wb(1'b1, RCR_OFF_PLAT, 32'hFFFF_FFFF);
    wb(1'b0, RCR_OFF_PLAT, 32'h0);
    chk("plat_ro", {1'b0, 11'h000, 4'hF, 16'h0000}, wd);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped_err", 1'b1, e);
    complete_run();
  end
endmodule : testbench
bind rcr_top rcr_monitor u_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_err_o, .cfg_valid_o, .plat_mult_o, .core_num_o,
  .core_den_o, .mem_mult_o, .mem_sync_o, .mem_pll_ref_en_o, .memory_clock_divide_setting_o,
  .pci_clk_sel_async_o);
`default_nettype wire
